/* File: rtl/mbrm_pkg.sv */
package mbrm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int FC_W = 8;
   localparam int NODE_W = 8;
   localparam int PT_W = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Per-node layout
   localparam int PTS_PER_NODE = 16;
   localparam int GRP_STRIDE = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Address windows, register numbers as printed (decimal in comments)
   localparam logic [15:0] NATIVE_FIRST = 16'h0001;
   localparam logic [15:0] GRP_IN_FIRST = 16'h0899;   // 2201
   localparam logic [15:0] GRP_IN_LAST = 16'h0A18;    // 2584
   localparam logic [15:0] GRP_OUT_FIRST = 16'h1131;  // 4401
   localparam logic [15:0] GRP_OUT_LAST = 16'h12B0;   // 4784
   localparam logic [15:0] BITPK_FIRST = 16'h19C9;    // 6601
   localparam logic [15:0] BITPK_LAST = 16'h1A61;     // 6753
   localparam logic [15:0] ANLG_FIRST = 16'h1A91;     // 6801
   localparam logic [15:0] ANLG_LAST = 16'h238A;      // 9098
   localparam logic [7:0] GRP_LAST_NODE = 8'h2F;      // 47

   ////////////////////////////////////////////////////////////////////////////////
   // Firmware level that unlocks the alternative map
   localparam logic [7:0] ALT_MIN_FW = 8'h03;

   ////////////////////////////////////////////////////////////////////////////////
   // Function codes and exception codes
   localparam logic [7:0] FC_RD_COILS = 8'h01;
   localparam logic [7:0] FC_RD_DISC = 8'h02;
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INREG = 8'h04;
   localparam logic [7:0] FC_WR_COIL = 8'h05;
   localparam logic [7:0] FC_WR_HOLD = 8'h06;
   localparam logic [7:0] FC_WR_COILS = 8'h0F;
   localparam logic [7:0] FC_WR_HOLDS = 8'h10;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] RST_DATA = 16'h0000;
   localparam logic [7:0] RST_NODE = 8'h00;
   localparam logic [3:0] RST_PT = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded region
   typedef enum logic [4:0] {
      RG_NONE = 5'b00001,
      RG_NATIVE = 5'b00010,
      RG_GRP_IN = 5'b00100,
      RG_GRP_OUT = 5'b01000,
      RG_RSVD = 5'b10000
   } mbrm_region_t;

endpackage : mbrm_pkg

/* File: rtl/mbrm_map.sv */
`timescale 1ns/1ps
module mbrm_map
   import mbrm_pkg::*;
#(
   parameter int MAX_NODES = 48,
   parameter int IDX_W = $clog2(MAX_NODES * PTS_PER_NODE)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [FC_W-1:0] req_func,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic alt_capable,
   input wire logic [7:0] fw_version,
   input wire logic [NODE_W-1:0] node_count,
   input wire logic loc_we,
   input wire logic [IDX_W-1:0] loc_idx,
   input wire logic [DATA_W-1:0] loc_wdata,
   output logic resp_valid,
   output logic resp_ok,
   output logic [7:0] resp_exc,
   output logic [DATA_W-1:0] resp_rdata,
   output logic [NODE_W-1:0] node_index,
   output logic [PT_W-1:0] io_point_index,
   output logic resp_is_input,
   output mbrm_region_t resp_region,
   output logic [DATA_W-1:0] loc_rdata
);

   localparam logic [15:0] MAX_NODES16 = 16'(MAX_NODES);

   ////////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [DATA_W-1:0] mem [MAX_NODES * PTS_PER_NODE];

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   logic alt_en;
   logic is_rd;
   logic is_wr;
   logic [15:0] nat_off;
   logic [15:0] in_off;
   logic [15:0] out_off;
   logic [15:0] node_cnt16;
   mbrm_region_t dec_region;
   logic [NODE_W-1:0] dec_node;
   logic [PT_W-1:0] dec_pt;
   logic [IDX_W-1:0] dec_idx;
   logic dec_store;
   logic host_we;

   always_comb begin
      alt_en = alt_capable && (fw_version >= ALT_MIN_FW);
      is_rd = (req_func == FC_RD_HOLD);
      is_wr = (req_func == FC_WR_HOLD) || (req_func == FC_WR_HOLDS);
      nat_off = req_addr - NATIVE_FIRST;
      in_off = req_addr - GRP_IN_FIRST;
      out_off = req_addr - GRP_OUT_FIRST;
      node_cnt16 = {8'h00, node_count};
      dec_region = RG_NONE;
      dec_node = RST_NODE;
      dec_pt = RST_PT;
      if ((req_addr >= NATIVE_FIRST) && ({4'h0, nat_off[15:4]} < node_cnt16)
          && ({4'h0, nat_off[15:4]} < MAX_NODES16)) begin
         dec_region = RG_NATIVE;
         dec_node = nat_off[11:4];
         dec_pt = nat_off[3:0];
      end else if (alt_en && (req_addr >= GRP_IN_FIRST) && (req_addr <= GRP_IN_LAST)
                   && ({3'h0, in_off[15:3]} < MAX_NODES16)) begin
         dec_region = RG_GRP_IN;
         dec_node = in_off[10:3];
         dec_pt = {1'b0, in_off[2:0]};
      end else if (alt_en && (req_addr >= GRP_OUT_FIRST) && (req_addr <= GRP_OUT_LAST)
                   && ({3'h0, out_off[15:3]} < MAX_NODES16)) begin
         dec_region = RG_GRP_OUT;
         dec_node = out_off[10:3];
         dec_pt = {1'b1, out_off[2:0]};
      end else if (alt_en && (((req_addr >= BITPK_FIRST) && (req_addr <= BITPK_LAST))
                   || ((req_addr >= ANLG_FIRST) && (req_addr <= ANLG_LAST)))) begin
         dec_region = RG_RSVD;
      end
      dec_idx = IDX_W'({dec_node, dec_pt});
      dec_store = (dec_region == RG_NATIVE) || (dec_region == RG_GRP_IN)
                  || (dec_region == RG_GRP_OUT);
      host_we = req_valid && is_wr && dec_store;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Response
   logic resp_valid_reg;
   logic resp_valid_next;
   logic resp_ok_reg;
   logic resp_ok_next;
   logic [7:0] resp_exc_reg;
   logic [7:0] resp_exc_next;
   logic [DATA_W-1:0] resp_rdata_reg;
   logic [DATA_W-1:0] resp_rdata_next;
   logic [NODE_W-1:0] node_index_reg;
   logic [NODE_W-1:0] node_index_next;
   logic [PT_W-1:0] io_point_index_reg;
   logic [PT_W-1:0] io_point_index_next;
   logic resp_is_input_reg;
   logic resp_is_input_next;
   mbrm_region_t resp_region_reg;
   mbrm_region_t resp_region_next;

   always_comb begin
      resp_valid_next = req_valid;
      resp_ok_next = 1'b0;
      resp_exc_next = EXC_NONE;
      resp_rdata_next = RST_DATA;
      node_index_next = node_index_reg;
      io_point_index_next = io_point_index_reg;
      resp_is_input_next = resp_is_input_reg;
      resp_region_next = resp_region_reg;
      if (req_valid) begin
         node_index_next = dec_node;
         io_point_index_next = dec_pt;
         resp_is_input_next = dec_store && !dec_pt[3];
         resp_region_next = dec_region;
         if (!(is_rd || is_wr)) begin
            resp_exc_next = EXC_ILL_FUNC;
         end else if (dec_region == RG_NONE) begin
            resp_exc_next = EXC_ILL_ADDR;
         end else begin
            resp_ok_next = 1'b1;
            if (is_rd && dec_store) begin
               resp_rdata_next = mem[dec_idx];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid_reg <= 1'b0;
         resp_ok_reg <= 1'b0;
         resp_exc_reg <= EXC_NONE;
         resp_rdata_reg <= RST_DATA;
         node_index_reg <= RST_NODE;
         io_point_index_reg <= RST_PT;
         resp_is_input_reg <= 1'b0;
         resp_region_reg <= RG_NONE;
      end else begin
         resp_valid_reg <= resp_valid_next;
         resp_ok_reg <= resp_ok_next;
         resp_exc_reg <= resp_exc_next;
         resp_rdata_reg <= resp_rdata_next;
         node_index_reg <= node_index_next;
         io_point_index_reg <= io_point_index_next;
         resp_is_input_reg <= resp_is_input_next;
         resp_region_reg <= resp_region_next;
      end
   end

   assign resp_valid = resp_valid_reg;
   assign resp_ok = resp_ok_reg;
   assign resp_exc = resp_exc_reg;
   assign resp_rdata = resp_rdata_reg;
   assign node_index = node_index_reg;
   assign io_point_index = io_point_index_reg;
   assign resp_is_input = resp_is_input_reg;
   assign resp_region = resp_region_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Storage write and local read; host write wins
   logic [DATA_W-1:0] loc_rdata_reg;
   logic [DATA_W-1:0] loc_rdata_next;

   always_comb begin
      loc_rdata_next = mem[loc_idx];
   end

   always_ff @(posedge clk) begin
      if (host_we) begin
         mem[dec_idx] <= req_wdata;
      end
      if (loc_we && !(host_we && (loc_idx == dec_idx))) begin
         mem[loc_idx] <= loc_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loc_rdata_reg <= RST_DATA;
      end else begin
         loc_rdata_reg <= loc_rdata_next;
      end
   end

   assign loc_rdata = loc_rdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_only_holding;
      @(posedge clk) disable iff (!rst_n)
      req_valid && !is_rd && !is_wr |=> resp_valid && !resp_ok && (resp_exc == EXC_ILL_FUNC);
   endproperty
   a_only_holding: assert property (p_only_holding) else $error("non-holding code accepted");

   property p_inreg_refused;
      @(posedge clk) disable iff (!rst_n)
      req_valid && (req_func == FC_RD_INREG) |=> !resp_ok && (resp_exc == EXC_ILL_FUNC);
   endproperty
   a_inreg_refused: assert property (p_inreg_refused) else $error("input register class accepted");

   property p_native_formula;
      @(posedge clk) disable iff (!rst_n)
      resp_ok && (resp_region == RG_NATIVE) |->
         ({node_index, io_point_index} == 12'($past(req_addr) - 16'h0001));
   endproperty
   a_native_formula: assert property (p_native_formula) else $error("native decode wrong");

   property p_gateway_first;
      @(posedge clk) disable iff (!rst_n)
      req_valid && is_rd && (req_addr == 16'h0010) && (node_count != 8'h00) |=>
         resp_ok && (node_index == 8'h00) && (io_point_index == 4'hF);
   endproperty
   a_gateway_first: assert property (p_gateway_first) else $error("gateway not at 1-16");

   property p_native_extends;
      @(posedge clk) disable iff (!rst_n)
      req_valid && is_rd && (req_addr >= 16'h0001)
         && (32'(req_addr) <= 32'(node_count) * 16) && (32'(node_count) <= MAX_NODES) |=>
         resp_ok && (resp_region == RG_NATIVE);
   endproperty
   a_native_extends: assert property (p_native_extends) else $error("native node refused");

   property p_alt_gated;
      @(posedge clk) disable iff (!rst_n)
      req_valid && !alt_en |=> (resp_region == RG_NONE) || (resp_region == RG_NATIVE);
   endproperty
   a_alt_gated: assert property (p_alt_gated) else $error("alt map decoded without support");

   property p_grp_in;
      @(posedge clk) disable iff (!rst_n)
      resp_valid && (resp_region == RG_GRP_IN) |-> !io_point_index[3]
         && ({node_index, io_point_index[2:0]} == 11'($past(req_addr) - GRP_IN_FIRST));
   endproperty
   a_grp_in: assert property (p_grp_in) else $error("grouped input decode wrong");

   property p_grp_out;
      @(posedge clk) disable iff (!rst_n)
      resp_valid && (resp_region == RG_GRP_OUT) |-> io_point_index[3]
         && ({node_index, io_point_index[2:0]} == 11'($past(req_addr) - GRP_OUT_FIRST));
   endproperty
   a_grp_out: assert property (p_grp_out) else $error("grouped output decode wrong");

   property p_last_node;
      @(posedge clk) disable iff (!rst_n)
      req_valid && is_rd && alt_en && (req_addr == GRP_OUT_LAST) && (MAX_NODES > 47) |=>
         resp_ok && (node_index == GRP_LAST_NODE) && (io_point_index == 4'hF);
   endproperty
   a_last_node: assert property (p_last_node) else $error("node 47 outputs not mapped");

   property p_reserved;
      @(posedge clk) disable iff (!rst_n)
      req_valid && is_rd && alt_en && (req_addr >= ANLG_FIRST) && (req_addr <= ANLG_LAST) |=>
         resp_ok && (resp_region == RG_RSVD) && (resp_rdata == RST_DATA);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved region mishandled");

   property p_split;
      @(posedge clk) disable iff (!rst_n)
      resp_ok && (resp_region == RG_NATIVE) |-> (resp_is_input == !io_point_index[3]);
   endproperty
   a_split: assert property (p_split) else $error("input/output split wrong");

   property p_alias;
      @(posedge clk) disable iff (!rst_n)
      host_we |=> (mem[$past(dec_idx)] == $past(req_wdata));
   endproperty
   a_alias: assert property (p_alias) else $error("write not visible in storage");

   property p_bitpk_reserved;
      @(posedge clk) disable iff (!rst_n)
      req_valid && is_wr && alt_en && (req_addr >= BITPK_FIRST) && (req_addr <= BITPK_LAST) |=>
         resp_ok && (resp_region == RG_RSVD);
   endproperty
   a_bitpk_reserved: assert property (p_bitpk_reserved) else $error("bit-packed region mishandled");

   property p_grp_in_last;
      @(posedge clk) disable iff (!rst_n)
      req_valid && is_rd && alt_en && (req_addr == GRP_IN_LAST) && (MAX_NODES > 47) |=>
         resp_ok && (resp_region == RG_GRP_IN) && (node_index == GRP_LAST_NODE) && (io_point_index == 4'h7);
   endproperty
   a_grp_in_last: assert property (p_grp_in_last) else $error("last input slot not mapped");

endmodule : mbrm_map

/* File: testbench/mbrm_host.sv */
`timescale 1ns/1ps
module mbrm_host
   import mbrm_pkg::*;
(
   input wire logic clk,
   output logic req_valid,
   output logic [FC_W-1:0] req_func,
   output logic [ADDR_W-1:0] req_addr,
   output logic [DATA_W-1:0] req_wdata
);
   initial begin
      req_valid = 1'b0;
      req_func = 8'h00;
      req_addr = 16'h0000;
      req_wdata = 16'h0000;
   end

   // Class from function code, bare location as address; no slot assumed live
   task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
      req_valid = 1'b1;
      req_func = f;
      req_addr = a;
      req_wdata = d;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      // Released lines show inverted leftovers
      req_func = ~f;
      req_addr = ~a;
      req_wdata = ~d;
   endtask : xfer
endmodule : mbrm_host

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import mbrm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic alt_capable = 1'b0;
   logic [7:0] fw_version = 8'h00;
   logic [NODE_W-1:0] node_count = 8'h30;
   logic loc_we = 1'b0;
   logic [9:0] loc_idx = 10'h000;
   logic [DATA_W-1:0] loc_wdata = 16'h0000;
   logic req_valid, resp_valid, resp_ok, resp_is_input;
   logic [FC_W-1:0] req_func;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_wdata, resp_rdata, loc_rdata;
   logic [7:0] resp_exc;
   logic [NODE_W-1:0] node_index;
   logic [PT_W-1:0] io_point_index;
   mbrm_region_t resp_region;
   int err_count = 0;
   int total_checks = 0;
   int mem[768];
   logic [31:0] rs = 32'd92181;
   int edges[26] = '{0, 1, 16, 17, 48, 49, 767, 768, 769, 2200, 2201, 2208, 2209, 2584, 2585,
      4400, 4401, 4784, 4785, 6600, 6601, 6753, 6754, 6800, 9098, 9099};
   logic [7:0] fcs[8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10};

   always #4 clk = ~clk;

   mbrm_host u_mbrm_host (.clk(clk), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
      .req_wdata(req_wdata));

   mbrm_map u_mbrm_map (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_func(req_func),
      .req_addr(req_addr), .req_wdata(req_wdata), .alt_capable(alt_capable), .fw_version(fw_version),
      .node_count(node_count), .loc_we(loc_we), .loc_idx(loc_idx), .loc_wdata(loc_wdata),
      .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_exc(resp_exc), .resp_rdata(resp_rdata),
      .node_index(node_index), .io_point_index(io_point_index), .resp_is_input(resp_is_input),
      .resp_region(resp_region), .loc_rdata(loc_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      if (err_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // One host request with the model's expected answer
   task automatic req(input logic [7:0] f, input int a, input logic [15:0] d);
      int nd, pt, ex, rg, lim;
      bit st, ae;
      ae = alt_capable && fw_version >= 3;
      lim = (node_count < 48 ? int'(node_count) : 48) * 16;
      ex = 0;
      rg = 1;
      nd = 0;
      pt = 0;
      if (a >= 1 && a <= lim) begin
         rg = 2;
         nd = (a - 1) / 16;
         pt = (a - 1) % 16;
      end else if (ae && a >= 2201 && a <= 2584) begin
         rg = 4;
         nd = (a - 2201) / 8;
         pt = (a - 2201) % 8;
      end else if (ae && a >= 4401 && a <= 4784) begin
         rg = 8;
         nd = (a - 4401) / 8;
         pt = (a - 4401) % 8 + 8;
      end else if (ae && ((a >= 6601 && a <= 6753) || (a >= 6801 && a <= 9098))) begin
         rg = 16;
      end else begin
         ex = 2;
      end
      if (!(f inside {FC_RD_HOLD, FC_WR_HOLD, FC_WR_HOLDS})) ex = 1;
      st = rg inside {2, 4, 8};
      if (ex == 0 && st && f != FC_RD_HOLD) mem[nd * 16 + pt] = d;
      u_mbrm_host.xfer(f, a[15:0], d);
      check(resp_valid, 1);
      check(resp_exc, ex);
      check(resp_ok, ex == 0);
      if (ex == 0) begin
         check(resp_region, rg);
         check(resp_rdata, (st && f == FC_RD_HOLD) ? mem[nd * 16 + pt] : 0);
         if (st) begin
            check(node_index, nd);
            check(io_point_index, pt);
            check(resp_is_input, pt < 8);
         end
      end
      @(posedge clk);
      #1;
   endtask : req

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      err_count++;
      finish_test();
   end

   initial begin
      logic [31:0] r;
      repeat (2) @(posedge clk);
      #1;
      check(resp_region, RG_NONE);
      check(resp_valid, 0);
      rst_n = 1'b1;
      for (int i = 0; i < 768; i++) begin
         r = rnd();
         loc_we = 1'b1;
         loc_idx = i[9:0];
         loc_wdata = r[15:0];
         mem[i] = r[15:0];
         @(posedge clk);
         #1;
      end
      loc_we = 1'b0;
      for (int k = 0; k < 8; k++) begin
         alt_capable = k[0];
         fw_version = k[1] ? 8'h03 : 8'h02;
         node_count = k[2] ? 8'h30 : 8'h03;
         foreach (edges[j]) begin
            req(FC_RD_HOLD, edges[j], 16'h0000);
            req(FC_WR_HOLD, edges[j], 16'(rnd()));
         end
      end
      foreach (fcs[j]) req(fcs[j], 17, 16'(rnd()));
      req(FC_WR_HOLDS, 4409, 16'hBEEF);
      req(FC_RD_HOLD, 25, 16'h0000);
      for (int i = 0; i < 400; i++) begin
         r = rnd();
         alt_capable = r[0] | r[1];
         fw_version = {6'h00, r[3:2]} + 8'h02;
         node_count = 8'(r[9:4] % 60 + 1);
         req(fcs[r[31:29]], edges[r[28:24] % 26] + int'(r[19:16]) - 8, r[15:0]);
      end
      for (int i = 0; i < 768; i++) begin
         loc_idx = i[9:0];
         @(posedge clk);
         #1;
         check(loc_rdata, mem[i]);
      end
      finish_test();
   end
endmodule : testbench
